// [switch_supervisor.sv]
// Supply over-voltage supervisor, input polling and per-input settings map
// Operation
// - over-voltage stops all currents and monitoring
// - entry drives alert low, sets event bit
// - live supply-high bit reads one meanwhile
// - pending flag shifted out while event pending
// - status read plus chip-select rise clears
// - link, settings, switch status kept during fault
// - one interrupt per ongoing over-voltage condition
// - exit drives alert low, sets event, clears live
// - resume polling at lowest enabled input
// - first cycle after recovery flags change, baseline
// - switch open/closed status readable
// - levels per four inputs, wetting per pair except inputs 4, 5, 10, 11, 22, 23
// - inputs 0-9 source or sink, default source
// - inputs 0-11 pick one of eight levels
// - four comparator levels 2, 2.7, 3, 4 V
`timescale 1ns/1ns
module switch_supervisor
  import msdi_pkg::*;
(
  input  wire logic                               clock,
  input  wire logic                               nrst,
  input  wire logic                               spi_clk,
  input  wire logic                               cs_n,
  input  wire logic                               mosi,
  output logic                                    miso,
  output logic                                    alert_n,
  output logic                                    pending_event_flag,
  input  wire logic                               vs_above_rise,
  input  wire logic                               vs_below_hyst,
  input  wire logic                               run_go,
  input  wire logic [NUM_IN-1:0]                  in_en,
  input  wire logic [NUM_SNK-1:0]                 sink_sel,
  input  wire logic [NUM_IN-1:0]                  switch_input_pin,
  input  comp_level_e                             comparator_level_select [NUM_GRP],
  input  wire logic [NUM_WSLOT-1:0][WC_W-1:0]     wetting_pair_setting,
  input  wire logic [NUM_ADC-1:0][2:0]            adc_slot_sel,
  input  wire logic [NUM_LVL-1:0][ADC_W-1:0]      adc_level,
  input  wire logic [ADC_W-1:0]                   adc_shared_level,
  output drive_s                                  drive,
  output logic [NUM_IN-1:0][WC_W-1:0]             wet_out,
  output comp_level_e                             comp_out [NUM_IN],
  output logic [NUM_ADC-1:0][ADC_W-1:0]           adc_thr,
  output logic [ADC_W-1:0]                        adc_shared_out,
  output status_s                                 status
);

  // Core-domain state
  supply_state_e     st_r, st_nxt;
  logic [1:0]        int_r, int_nxt;
  logic [NUM_IN-1:0] cur_r, cur_nxt, stat_r, stat_nxt;
  logic [4:0]        ptr_r, ptr_nxt;
  logic              base_r, base_nxt, seen_r, seen_nxt;
  logic [NUM_SNK-1:0] sel_r, sel_nxt;
  status_s           snap_r, snap_nxt;
  logic              link_rst_r;
  logic              sce, active, ov_enter, ov_exit, cs_rise, tg_edge, clr;
  // Synchroniser stages
  logic [1:0]        vs_s1, vs_s2;
  logic [NUM_IN-1:0] sw_s1, sw_s2;
  logic              cs_s1, cs_s2, cs_s3, tg_s1, tg_s2, tg_s3;
  // Link-domain state
  logic [4:0]        cnt_r, cnt_nxt;
  logic [7:0]        cmd_r, cmd_nxt, cmd_full;
  logic              tgl_r, tgl_nxt;
  logic [NUM_IN-1:0] word;

  // Lowest enabled input
  function automatic logic [4:0] first_en(input logic [NUM_IN-1:0] en);
    logic [4:0] f;
    f = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (en[i]) begin
        f = 5'(i);
      end
    end
    return f;
  endfunction

  // Two-stage synchronisers for pins and link events
  always_ff @(posedge clock) begin
    if (!nrst) begin
      vs_s1 <= '0;
      vs_s2 <= '0;
      sw_s1 <= '0;
      sw_s2 <= '0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      vs_s1 <= {vs_below_hyst, vs_above_rise};
      vs_s2 <= vs_s1;
      sw_s1 <= switch_input_pin;
      sw_s2 <= sw_s1;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tg_s1 <= tgl_r;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  assign cs_rise = cs_s2 & ~cs_s3;
  assign tg_edge = tg_s2 ^ tg_s3;
  assign clr     = cs_rise & (seen_r | tg_edge);
  assign active  = (st_r == ST_RUN) & run_go;
  assign ov_enter = (st_r == ST_RUN) & vs_s2[0];
  assign ov_exit  = (st_r == ST_OVER) & vs_s2[1];

  // Supply state, interrupt bits, polling
  always_comb begin
    st_nxt   = st_r;
    ptr_nxt  = ptr_r;
    cur_nxt  = cur_r;
    stat_nxt = stat_r;
    base_nxt = base_r;
    sce      = 1'b0;
    if (ov_enter) begin
      st_nxt = ST_OVER;
    end else if (ov_exit) begin
      st_nxt = ST_RUN;
    end
    if (!active) begin
      ptr_nxt = first_en(in_en);
      if (st_r == ST_OVER) begin
        base_nxt = 1'b0;
      end
    end else begin
      cur_nxt[ptr_r] = in_en[ptr_r] & sw_s2[ptr_r];
      if (ptr_r == LAST_IN) begin
        stat_nxt = cur_nxt;
        sce      = !base_r || (cur_nxt != stat_r);
        base_nxt = 1'b1;
        ptr_nxt  = first_en(in_en);
      end else begin
        ptr_nxt = ptr_r + 5'h01;
      end
    end
    // Events win over a clear in the same cycle
    int_nxt = clr ? 2'b00 : int_r;
    if (ov_enter || ov_exit) begin
      int_nxt[INT_OV_BIT] = 1'b1;
    end
    if (sce) begin
      int_nxt[INT_SCE_BIT] = 1'b1;
    end
    seen_nxt = cs_rise ? 1'b0 : (seen_r | tg_edge);
    // Snapshot frozen while chip select is low
    snap_nxt = cs_s2 ? status : snap_r;
    sel_nxt  = run_go ? sel_r : sink_sel;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r       <= ST_RUN;
      int_r      <= '0;
      cur_r      <= '0;
      stat_r     <= '0;
      ptr_r      <= '0;
      base_r     <= 1'b0;
      seen_r     <= 1'b0;
      sel_r      <= SEL_RESET;
      snap_r     <= '0;
      link_rst_r <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      int_r      <= int_nxt;
      cur_r      <= cur_nxt;
      stat_r     <= stat_nxt;
      ptr_r      <= ptr_nxt;
      base_r     <= base_nxt;
      seen_r     <= seen_nxt;
      sel_r      <= sel_nxt;
      snap_r     <= snap_nxt;
      link_rst_r <= 1'b0;
    end
  end

  assign alert_n            = ~|int_r;
  assign pending_event_flag = |int_r;
  assign status             = '{sw: stat_r, int_stat: int_r, ov_live: st_r == ST_OVER};

  // Link side: command shift, bit count, status-read toggle
  assign cmd_full = {cmd_r[6:0], mosi};
  always_comb begin
    cnt_nxt = (cnt_r == FRAME_END) ? cnt_r : cnt_r + 5'h01;
    cmd_nxt = (cnt_r <= CMD_LAST) ? cmd_full : cmd_r;
    tgl_nxt = tgl_r ^ ((cnt_r == CMD_LAST) && (cmd_full == ADDR_INT_STAT));
  end

  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      cnt_r <= '0;
      cmd_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  always_ff @(posedge spi_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      tgl_r <= 1'b0;
    end else begin
      tgl_r <= tgl_nxt;
    end
  end

  // Read word select from the frozen snapshot
  always_comb begin
    word = '0;
    if (cmd_r == ADDR_INT_STAT) begin
      word[1:0] = snap_r.int_stat;
    end else if (cmd_r == ADDR_MISC) begin
      word[0] = snap_r.ov_live;
    end else if (cmd_r == ADDR_SW) begin
      word = snap_r.sw;
    end
  end

  // First bit is the pending flag, then zeros, then data
  assign miso = (cnt_r == 5'h00) ? |snap_r.int_stat :
                (cnt_r <= CMD_LAST) ? 1'b0 : word[5'h1F - cnt_r];

  // Per-input settings map, drive and wetting gated off outside normal run
  logic [NUM_IN-1:0]            src_nxt;
  logic [NUM_SNK-1:0]           snk_nxt;
  logic [NUM_IN-1:0][WC_W-1:0]  wet_nxt;
  logic [NUM_ADC-1:0][ADC_W-1:0] thr_nxt;
  comp_level_e                  cmp_nxt [NUM_IN];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      assign wet_nxt[gi] = active ? wetting_pair_setting[WET_SLOT[gi]] : WC_RESET;
      assign cmp_nxt[gi] = comparator_level_select[gi / GRP_SIZE];
      if (gi < NUM_SNK) begin : g_sel
        assign src_nxt[gi] = active & in_en[gi] & ~sel_r[gi];
        assign snk_nxt[gi] = active & in_en[gi] & sel_r[gi];
      end else begin : g_src
        assign src_nxt[gi] = active & in_en[gi];
      end
      if (gi < NUM_ADC) begin : g_adc
        assign thr_nxt[gi] = adc_level[adc_slot_sel[gi]];
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!nrst) begin
      drive          <= '0;
      wet_out        <= '0;
      adc_thr        <= '0;
      adc_shared_out <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        comp_out[i] <= LVL_2V0;
      end
    end else begin
      drive          <= '{src_en: src_nxt, snk_en: snk_nxt};
      wet_out        <= wet_nxt;
      adc_thr        <= thr_nxt;
      adc_shared_out <= adc_shared_level;
      comp_out       <= cmp_nxt;
    end
  end

  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence recover_s;
    ov_exit ##1 active [*8];
  endsequence

  ov_entry_a: assert property (ov_enter |=> st_r == ST_OVER && int_r[INT_OV_BIT] && !alert_n)
    else $error("entry did not raise event");
  drive_off_a: assert property (st_r == ST_OVER |=> drive == '0 && wet_out == '0)
    else $error("currents on during fault");
  live_bit_a: assert property ((ov_enter || (status.ov_live && !ov_exit)) |=> status.ov_live)
    else $error("live bit dropped in fault");
  pend_flag_a: assert property (cs_s2 && int_r != 2'b00 |=> snap_r.int_stat != 2'b00)
    else $error("pending flag lost");
  clear_a: assert property (clr && !ov_enter && !ov_exit && !sce |=> int_r == 2'b00 && alert_n)
    else $error("read did not clear");
  hold_a: assert property (int_r != 2'b00 && !clr |=> int_r != 2'b00)
    else $error("event lost without read");
  stat_hold_a: assert property (st_r == ST_OVER |=> $stable(stat_r))
    else $error("status changed in fault");
  exit_a: assert property (ov_exit |=> !status.ov_live && int_r[INT_OV_BIT] && !alert_n)
    else $error("exit not flagged");
  restart_a: assert property (ov_exit |=> ptr_r == first_en($past(in_en)))
    else $error("polling not restarted");
  sce_a: assert property (recover_s |-> ##[0:24] (int_r[INT_SCE_BIT] || clr))
    else $error("no change event after recovery");
  pair_a: assert property (wet_out[0] == wet_out[1] && wet_out[18] == wet_out[19])
    else $error("paired wetting differ");

endmodule

// [msdi_pkg.sv]
// Constants, types and carriers for the supply and input-setup block
package msdi_pkg;
  localparam int NUM_IN    = 24;
  localparam int NUM_SNK   = 10;
  localparam int NUM_ADC   = 12;
  localparam int NUM_GRP   = 6;
  localparam int GRP_SIZE  = 4;
  localparam int NUM_WSLOT = 15;
  localparam int NUM_LVL   = 8;
  localparam int ADC_W     = 10;
  localparam int WC_W      = 3;
  // Link frame: 8 command bits then 24 data bits
  localparam logic [4:0] CMD_LAST  = 5'h07;
  localparam logic [4:0] FRAME_END = 5'h1F;
  localparam logic [4:0] LAST_IN   = 5'h17;
  // Readable words on the link
  localparam logic [7:0] ADDR_INT_STAT = 8'h01;
  localparam logic [7:0] ADDR_MISC     = 8'h02;
  localparam logic [7:0] ADDR_SW       = 8'h03;
  // Field positions
  localparam int INT_OV_BIT  = 0;
  localparam int INT_SCE_BIT = 1;
  // Reset values
  localparam logic [WC_W-1:0]    WC_RESET  = 3'h0;
  localparam logic [NUM_SNK-1:0] SEL_RESET = 10'h000;
  // Wetting slot used by each input: pairs share one slot, inputs 4, 5, 10, 11, 22, 23 have their own
  localparam logic [3:0] WET_SLOT [NUM_IN] = '{
    4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7,
    4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'hB, 4'hB, 4'hC, 4'hC, 4'hD, 4'hE};
  typedef enum logic [1:0] {
    LVL_2V0 = 2'h0,
    LVL_2V7 = 2'h1,
    LVL_3V0 = 2'h2,
    LVL_4V0 = 2'h3
  } comp_level_e;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_OVER = 2'b10
  } supply_state_e;
  typedef struct packed {
    logic [NUM_IN-1:0] sw;
    logic [1:0]        int_stat;
    logic              ov_live;
  } status_s;
  typedef struct packed {
    logic [NUM_IN-1:0]  src_en;
    logic [NUM_SNK-1:0] snk_en;
  } drive_s;
endpackage

// [link_host.sv]
// Host model that runs link frames toward the supervisor
`timescale 1ns/1ns
module link_host (
  output logic      spi_clk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Idle link: clock parked low, frame deselected
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame: address msb first, 32 bits captured on each rise
  task automatic xfer(input logic [7:0] addr, output logic [31:0] rx);
    cs_n = 1'b0;
    #43;
    for (int k = 0; k < 32; k++) begin
      mosi = (k < 8) ? addr[7 - k] : 1'b0;
      #24 spi_clk = 1'b1;
      rx[31 - k] = miso;
      #24 spi_clk = 1'b0;
    end
    cs_n = 1'b1;
    mosi = ~mosi; // Released line never shows the last bit
    #45;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the supply supervisor and settings map
`timescale 1ns/1ns
module tb;
  import msdi_pkg::*;
  logic                           clock, nrst, spi_clk, cs_n, mosi, miso, alert_n, pend, above, below, run_go;
  logic [NUM_IN-1:0]              in_en, pins;
  logic [NUM_SNK-1:0]             sink_sel;
  comp_level_e                    cls [NUM_GRP];
  comp_level_e                    comp_out [NUM_IN];
  logic [NUM_WSLOT-1:0][WC_W-1:0] wps;
  logic [NUM_ADC-1:0][2:0]        slot_sel;
  logic [NUM_LVL-1:0][ADC_W-1:0]  lvl;
  logic [ADC_W-1:0]               shared, shared_out;
  drive_s                         drive;
  logic [NUM_IN-1:0][WC_W-1:0]    wet_out;
  logic [NUM_ADC-1:0][ADC_W-1:0]  adc_thr;
  status_s                        status;
  logic [31:0]                    rx;
  int                             err_total, total_checks;
  // Design and host model
  switch_supervisor uut (.clock(clock), .nrst(nrst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .alert_n(alert_n), .pending_event_flag(pend), .vs_above_rise(above), .vs_below_hyst(below), .run_go(run_go),
    .in_en(in_en), .sink_sel(sink_sel), .switch_input_pin(pins), .comparator_level_select(cls),
    .wetting_pair_setting(wps), .adc_slot_sel(slot_sel), .adc_level(lvl), .adc_shared_level(shared),
    .drive(drive), .wet_out(wet_out), .comp_out(comp_out), .adc_thr(adc_thr), .adc_shared_out(shared_out),
    .status(status));
  link_host host (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Verdict and end of run
  task automatic end_sim;
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(a, rx);
    cyc(2);
  endtask
  // Watchdog
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  // Test sequence
  initial begin
    nrst = 1'b0;
    above = 1'b0;
    below = 1'b0;
    run_go = 1'b0;
    in_en = '1;
    pins = 24'hA5C33C;
    sink_sel = 10'h155;
    shared = 10'h2A5;
    for (int i = 0; i < NUM_WSLOT; i++) wps[i] = WC_W'(i % 7);
    for (int i = 0; i < NUM_GRP; i++) cls[i] = comp_level_e'(i % 4);
    for (int i = 0; i < NUM_ADC; i++) slot_sel[i] = 3'((i * 3) % 8);
    for (int i = 0; i < NUM_LVL; i++) lvl[i] = ADC_W'(i * 37 + 5);
    cyc(3);
    nrst = 1'b1;
    cyc(4);
    chk({alert_n, pend, status}, {2'b10, 27'h0});
    run_go = 1'b1;
    cyc(30);
    for (int i = 0; i < NUM_IN; i++) begin
      chk(wet_out[i], wps[WET_SLOT[i]]);
      chk(comp_out[i], cls[i / 4]);
    end
    for (int i = 0; i < NUM_ADC; i++) chk(adc_thr[i], lvl[slot_sel[i]]);
    chk(shared_out, shared);
    chk(drive, {14'h3FFF, ~sink_sel, sink_sel});
    chk({alert_n, status.int_stat[INT_SCE_BIT]}, 2'b01);
    rd(ADDR_MISC);
    chk({alert_n, rx[31], rx[0]}, 3'b010);
    rd(ADDR_SW);
    chk(rx[23:0], pins);
    rd(ADDR_INT_STAT);
    chk({rx[1:0], alert_n, status.int_stat}, 5'b10100);
    // Supply over-voltage entry
    above = 1'b1;
    cyc(3);
    chk({status.ov_live, status.int_stat[INT_OV_BIT], alert_n}, 3'b110);
    cyc(1);
    chk(drive, 40'h0);
    chk(wet_out[4], 3'h0);
    pins = 24'h00FF00;
    cyc(30);
    chk(status.sw, 24'hA5C33C);
    rd(ADDR_MISC);
    chk({rx[31], rx[0]}, 2'b11);
    rd(ADDR_SW);
    chk(rx[23:0], 24'hA5C33C);
    rd(ADDR_INT_STAT);
    chk(alert_n, 1'b1);
    cyc(20);
    chk({alert_n, pend}, 2'b10);
    chk(comp_out[5], cls[1]);
    // Supply recovery
    above = 1'b0;
    below = 1'b1;
    cyc(3);
    chk({status.ov_live, status.int_stat[INT_OV_BIT], alert_n}, 3'b010);
    cyc(30);
    chk(drive, {14'h3FFF, ~sink_sel, sink_sel});
    chk(wet_out[4], wps[2]);
    chk({status.sw, status.int_stat[INT_SCE_BIT]}, {pins, 1'b1});
    below = 1'b0;
    // Unchanged switches after the new baseline raise no change event
    rd(ADDR_INT_STAT);
    chk({rx[1:0], alert_n, status.int_stat}, 5'b11100);
    cyc(30);
    chk({alert_n, status.int_stat}, 3'b100);
    // A later change against the baseline is flagged
    pins = 24'h0000FF;
    cyc(60);
    chk({status.sw, status.int_stat[INT_SCE_BIT]}, {24'h0000FF, 1'b1});
    end_sim();
  end
endmodule
